// *** logic/dar_arm.sv ***
// One access arm: private address register and seek timer
`timescale 1ns/1ps
`default_nettype none
`include "dar_defs.svh"

module dar_arm #(
   parameter int unsigned SEEK_CYCLES = 32'(`DAR_SEEK_CYCLES),
   parameter int unsigned CNT_W       = `DAR_CNT_W
) (
   // Clock, reset, enable
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic ce_in,
   // Router side
   dar_arm_if.arm    port
);

   dar_pkg::dar_arm_state_t state_ff,  nxt_state;
   logic [CNT_W-1:0]        cnt_ff,    nxt_cnt;
   dar_pkg::dar_addr_t      addr_ff,   nxt_addr;
   logic                    busy_ff,   nxt_busy;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_addr  = addr_ff;
      unique case (state_ff)
         dar_pkg::ARM_IDLE:
         begin
            if (port.start)
            begin
               nxt_addr  = port.addr;  // [RULE_08]
               nxt_cnt   = CNT_W'(SEEK_CYCLES - 1);  // [RULE_07]
               nxt_state = dar_pkg::ARM_MOVE;
            end
         end
         dar_pkg::ARM_MOVE:
         begin
            // Only the private register steers the move [RULE_09]
            if (cnt_ff == '0)
               nxt_state = dar_pkg::ARM_IDLE;
            else
               nxt_cnt = cnt_ff - CNT_W'(1);
         end
         default:
            nxt_state = dar_pkg::ARM_IDLE;
      endcase
      nxt_busy = (nxt_state == dar_pkg::ARM_MOVE);
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         state_ff <= dar_pkg::ARM_IDLE;
         cnt_ff   <= '0;
         addr_ff  <= `DAR_RST_ADDR;
         busy_ff  <= 1'b0;
      end
      else if (ce_in)
      begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         addr_ff  <= nxt_addr;
         busy_ff  <= nxt_busy;
      end
   end

   assign port.busy = busy_ff;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_start;
      ce_in && state_ff == dar_pkg::ARM_IDLE && port.start;
   endsequence

   chk_addr_load: assert property (s_start |=> addr_ff == $past(port.addr)) // [RULE_08]
      else $error("arm did not load the buffered address");
   chk_seek_hold: assert property (s_start |=> busy_ff [*8]) // [RULE_07]
      else $error("arm seek ended too early");
   chk_addr_locked: assert property (busy_ff |=> $stable(addr_ff)) // [RULE_09]
      else $error("private address changed during seek");

endmodule : dar_arm

`default_nettype wire

// *** logic/dar_arm_if.sv ***
// Link between the router core and one access arm
`timescale 1ns/1ps
`default_nettype none

interface dar_arm_if;
   logic              start;
   dar_pkg::dar_addr_t addr;
   logic              busy;

   modport ctrl (output start, output addr, input busy);
   modport arm  (input start, input addr, output busy);
endinterface : dar_arm_if

`default_nettype wire

// *** logic/dar_defs.svh ***
// Constants of the disk access address router
`ifndef DAR_DEFS_SVH
`define DAR_DEFS_SVH

// Seek address: five decimal digits, high-order digit in the top nibble
`define DAR_ADDR_W        20
`define DAR_HI_DIGIT_MSB  19
`define DAR_HI_DIGIT_LSB  16
// First high-order digit served by the second file (50000 and up)
`define DAR_HALF_DIGIT    4'h5
// Tenth-character control code that keeps the read/write arm on the seeking arm
`define DAR_HOLD_CODE     4'h4

// Timing
`define DAR_CLK_HZ        10000000
`define DAR_SEEK_TIME_MS  600
`define DAR_SEEK_CYCLES   ((64'd`DAR_SEEK_TIME_MS * 64'd`DAR_CLK_HZ) / 64'd1000)
`define DAR_CNT_W         23

// Reset values
`define DAR_RST_ARM       1'b0
`define DAR_RST_FILE      1'b0
`define DAR_RST_ADDR      20'h0_0000

`endif

// *** logic/dar_pkg.sv ***
// Types of the disk access address router
package dar_pkg;

   typedef logic [19:0] dar_addr_t;

   typedef enum logic [1:0] {
      ARM_IDLE = 2'b01,
      ARM_MOVE = 2'b10
   } dar_arm_state_t;

endpackage : dar_pkg

// *** logic/dar_router.sv ***
// Disk access address router: file and arm steering for seeks and read/write
//
// Contract
// [RULE_01] Addresses 50000-99999 go to second file
// [RULE_02] One shared register; file chosen at half-way
// [RULE_03] Upper addresses never folded by subtracting five
// [RULE_04] Arms of both files never move together
// [RULE_05] Read/write uses last delivered address
// [RULE_06] Program readdresses a file before rewriting
// [RULE_07] Each arm seeks about six hundred milliseconds
// [RULE_08] Address buffered, then copied to arm, seek starts
// [RULE_09] Moving arm follows only its private register
// [RULE_10] One arm reads while the other seeks
// [RULE_11] Auto mode alternates arm 0 and 1
// [RULE_12] Select inputs choose arm for next seek
// [RULE_13] Permanent selection behaves as single-arm file
// [RULE_14] Mode input may change during operation
// [RULE_15] First seek arm 0; previous arm reads
// [RULE_16] Code four keeps read on seeking arm
// [RULE_17] Seek conditions other arm for next read
// [RULE_18] Selected arm takes all commands until reselected
// [RULE_19] Interlock stalls seek until other file idle
`timescale 1ns/1ps
`default_nettype none
`include "dar_defs.svh"

module dar_router #(
   parameter int unsigned SEEK_CYCLES = 32'(`DAR_SEEK_CYCLES),
   parameter int unsigned ADDR_W      = `DAR_ADDR_W
) (
   // Clock, reset, enable
   input  wire logic              CORE_CLK_IN,
   input  wire logic              RST_N_IN,
   input  wire logic              CE_IN,
   // Configuration and arm selection
   input  wire logic              SECOND_FILE_IN,
   input  wire logic              SEL_MODE_IN,
   input  wire logic              SEL_ARM0_IN,
   input  wire logic              SEL_ARM1_IN,
   // Seek request
   input  wire logic              SEEK_REQ_IN,
   input  wire logic [ADDR_W-1:0] SEEK_ADDR_IN,
   input  wire logic [3:0]        SEEK_CODE_IN,
   output logic                   SEEK_READY_OUT,
   output logic                   ADDR_ERR_OUT,
   // Read/write request
   input  wire logic              RW_REQ_IN,
   output logic                   RW_STROBE_OUT,
   output logic                   RW_FILE_OUT,
   output logic                   RW_ARM_OUT,
   output logic [ADDR_W-1:0]      RW_ADDR_OUT,
   // Arm status
   output logic [3:0]             SEEK_START_OUT,
   output logic [3:0]             ARM_BUSY_OUT
);

   function automatic logic upper_half(input logic [ADDR_W-1:0] a);
      // Compare only; the address itself is passed on unaltered
      upper_half = (a[`DAR_HI_DIGIT_MSB:`DAR_HI_DIGIT_LSB] >= `DAR_HALF_DIGIT);
   endfunction : upper_half

   dar_arm_if arm_if [4] ();
   logic [3:0] busy_w;

   // Shared seek buffer and request state
   logic [ADDR_W-1:0] jbuf_ff,   nxt_jbuf;
   logic              pend_ff,   nxt_pend;
   logic              ready_ff,  nxt_ready;
   logic              file_ff,   nxt_file;
   logic              hold_ff,   nxt_hold;
   logic              err_ff,    nxt_err;
   // Arm sequencing
   logic              seek_arm_ff, nxt_seek_arm;
   logic              prev_arm_ff, nxt_prev_arm;
   logic              rw_arm_ff,   nxt_rw_arm;
   logic              rw_file_ff,  nxt_rw_file;
   logic              sel_arm_ff,  nxt_sel_arm;
   logic [3:0]        start_ff,    nxt_start;
   logic [3:0]        busy_ff;
   // Read/write state
   logic              rw_pend_ff,  nxt_rw_pend;
   logic              rw_stb_ff,   nxt_rw_stb;
   logic              rw_fo_ff,    nxt_rw_fo;
   logic              rw_ao_ff,    nxt_rw_ao;
   logic [ADDR_W-1:0] rw_addr_ff,  nxt_rw_addr;

   logic              accept;
   logic              issue;
   logic              interlock;
   logic              tgt_arm;
   logic [1:0]        tgt_idx;
   logic              rw_arm_eff;
   logic [1:0]        rw_idx;
   logic              rw_grant;

   always_comb
   begin
      accept     = CE_IN && SEEK_REQ_IN && ready_ff;
      // Mode is read live, so a program may switch at any time [RULE_14]
      tgt_arm    = SEL_MODE_IN ? sel_arm_ff : seek_arm_ff;  // [RULE_11] [RULE_12] [RULE_13]
      tgt_idx    = {file_ff, tgt_arm};
      // Arm numbers of the other file busy: hold this seek [RULE_04] [RULE_19]
      interlock  = file_ff ? |busy_w[1:0] : |busy_w[3:2];
      issue      = CE_IN && pend_ff && !interlock && !busy_w[tgt_idx];
      rw_arm_eff = SEL_MODE_IN ? sel_arm_ff : rw_arm_ff;  // [RULE_18]
      rw_idx     = {rw_file_ff, rw_arm_eff};
      // Positioned arm serves while the other one may still move [RULE_10]
      // A start pulse still on its way means the arm is about to move
      rw_grant   = CE_IN && rw_pend_ff && !busy_w[rw_idx] && !start_ff[rw_idx];
   end

   // Seek path
   always_comb
   begin
      nxt_jbuf     = jbuf_ff;
      nxt_pend     = pend_ff;
      nxt_file     = file_ff;
      nxt_hold     = hold_ff;
      nxt_err      = err_ff;
      nxt_seek_arm = seek_arm_ff;
      nxt_prev_arm = prev_arm_ff;
      nxt_rw_arm   = rw_arm_ff;
      nxt_rw_file  = rw_file_ff;
      nxt_sel_arm  = sel_arm_ff;
      nxt_start    = 4'h0;
      // Select inputs only count in select mode
      if (SEL_MODE_IN && SEL_ARM0_IN)
         nxt_sel_arm = 1'b0;  // [RULE_12] [RULE_18]
      else if (SEL_MODE_IN && SEL_ARM1_IN)
         nxt_sel_arm = 1'b1;  // [RULE_12] [RULE_18]
      if (issue)
      begin
         nxt_pend            = 1'b0;
         nxt_start[tgt_idx]  = 1'b1;  // [RULE_08]
         nxt_prev_arm        = tgt_arm;
         nxt_rw_file         = file_ff;  // [RULE_05]
         if (!SEL_MODE_IN)
         begin
            nxt_seek_arm = ~seek_arm_ff;  // [RULE_11]
            // Code four: same arm seeks and reads; else the prior seek's arm [RULE_16]
            nxt_rw_arm   = hold_ff ? tgt_arm : prev_arm_ff;  // [RULE_15] [RULE_17]
         end
      end
      if (accept)
      begin
         nxt_jbuf = SEEK_ADDR_IN;  // [RULE_02] [RULE_03]
         nxt_pend = 1'b1;
         nxt_file = SECOND_FILE_IN && upper_half(SEEK_ADDR_IN);  // [RULE_01] [RULE_02]
         nxt_hold = (SEEK_CODE_IN == `DAR_HOLD_CODE);
         // No second file: flag, and the first file is not refolded onto
         nxt_err  = !SECOND_FILE_IN && upper_half(SEEK_ADDR_IN);  // [RULE_03]
      end
      nxt_ready = !nxt_pend;  // [RULE_19]
   end

   // Read/write path
   always_comb
   begin
      nxt_rw_pend = rw_pend_ff;
      nxt_rw_stb  = 1'b0;
      nxt_rw_fo   = rw_fo_ff;
      nxt_rw_ao   = rw_ao_ff;
      nxt_rw_addr = rw_addr_ff;
      if (rw_grant)
      begin
         nxt_rw_pend = 1'b0;
         nxt_rw_stb  = 1'b1;
         nxt_rw_fo   = rw_file_ff;
         nxt_rw_ao   = rw_arm_eff;
         // Always the last delivered address; rewrites rely on readdressing [RULE_05] [RULE_06]
         nxt_rw_addr = jbuf_ff;
      end
      // A request landing with a grant is kept, not lost
      if (CE_IN && RW_REQ_IN)
         nxt_rw_pend = 1'b1;
   end

   always_ff @(posedge CORE_CLK_IN)
   begin
      if (!RST_N_IN)
      begin
         jbuf_ff     <= `DAR_RST_ADDR;
         pend_ff     <= 1'b0;
         ready_ff    <= 1'b0;
         file_ff     <= `DAR_RST_FILE;
         hold_ff     <= 1'b0;
         err_ff      <= 1'b0;
         seek_arm_ff <= `DAR_RST_ARM;  // [RULE_15]
         prev_arm_ff <= `DAR_RST_ARM;
         rw_arm_ff   <= `DAR_RST_ARM;
         rw_file_ff  <= `DAR_RST_FILE;
         sel_arm_ff  <= `DAR_RST_ARM;
         start_ff    <= 4'h0;
         busy_ff     <= 4'h0;
         rw_pend_ff  <= 1'b0;
         rw_stb_ff   <= 1'b0;
         rw_fo_ff    <= `DAR_RST_FILE;
         rw_ao_ff    <= `DAR_RST_ARM;
         rw_addr_ff  <= `DAR_RST_ADDR;
      end
      else if (CE_IN)
      begin
         jbuf_ff     <= nxt_jbuf;
         pend_ff     <= nxt_pend;
         ready_ff    <= nxt_ready;
         file_ff     <= nxt_file;
         hold_ff     <= nxt_hold;
         err_ff      <= nxt_err;
         seek_arm_ff <= nxt_seek_arm;
         prev_arm_ff <= nxt_prev_arm;
         rw_arm_ff   <= nxt_rw_arm;
         rw_file_ff  <= nxt_rw_file;
         sel_arm_ff  <= nxt_sel_arm;
         start_ff    <= nxt_start;
         busy_ff     <= busy_w;
         rw_pend_ff  <= nxt_rw_pend;
         rw_stb_ff   <= nxt_rw_stb;
         rw_fo_ff    <= nxt_rw_fo;
         rw_ao_ff    <= nxt_rw_ao;
         rw_addr_ff  <= nxt_rw_addr;
      end
   end

   for (genvar g = 0; g < 4; g++)
   begin : g_arm
      assign arm_if[g].start = start_ff[g];
      assign arm_if[g].addr  = jbuf_ff;
      assign busy_w[g]       = arm_if[g].busy;
      dar_arm #(
         .SEEK_CYCLES (SEEK_CYCLES)
      ) u_arm (
         .clk_in   (CORE_CLK_IN),
         .rst_n_in (RST_N_IN),
         .ce_in    (CE_IN),
         .port     (arm_if[g])
      );
   end

   assign SEEK_READY_OUT = ready_ff;
   assign ADDR_ERR_OUT   = err_ff;
   assign RW_STROBE_OUT  = rw_stb_ff;
   assign RW_FILE_OUT    = rw_fo_ff;
   assign RW_ARM_OUT     = rw_ao_ff;
   assign RW_ADDR_OUT    = rw_addr_ff;
   assign SEEK_START_OUT = start_ff;
   // Registered copy, one cycle behind the arms
   assign ARM_BUSY_OUT   = busy_ff;

   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   sequence s_auto_issue;
      issue && !SEL_MODE_IN;
   endsequence

   chk_file_route: assert property (issue |-> file_ff == (SECOND_FILE_IN ? upper_half(jbuf_ff) : 1'b0) || $changed(SECOND_FILE_IN)) // [RULE_01]
      else $error("seek routed to wrong file");
   chk_no_dual_move: assert property (!((|busy_w[1:0]) && (|busy_w[3:2]))) // [RULE_04]
      else $error("arms of both files moving");
   chk_stall_hold: assert property (pend_ff && interlock |=> pend_ff && !ready_ff) // [RULE_19]
      else $error("interlocked seek released early");
   chk_rw_last_addr: assert property (rw_stb_ff |-> rw_addr_ff == $past(jbuf_ff)) // [RULE_05]
      else $error("read/write address is not the last delivered one");
   chk_auto_alternate: assert property (s_auto_issue |=> seek_arm_ff != $past(seek_arm_ff)) // [RULE_11]
      else $error("automatic sequencing did not alternate");
   chk_select_arm: assert property (issue && SEL_MODE_IN |=> start_ff[{file_ff, $past(sel_arm_ff)}]) // [RULE_18]
      else $error("select mode seek went to unselected arm");
   chk_hold_code: assert property (s_auto_issue and hold_ff |=> rw_arm_ff == $past(tgt_arm)) // [RULE_16]
      else $error("code four did not keep read on seeking arm");
   chk_prev_reads: assert property (s_auto_issue and !hold_ff |=> rw_arm_ff == $past(prev_arm_ff)) // [RULE_17]
      else $error("read arm not the previous seek arm");

endmodule : dar_router

`default_nettype wire

// *** test/dar_cpu_model.sv ***
// Processor-side model: issues seek and read/write requests
`timescale 1ns/1ps
`default_nettype none

module dar_cpu_model (
   // Clock and buffer status
   input  wire logic       clk_in,
   input  wire logic       ready_in,
   // Requests
   output var logic        seek_req_out,
   output var logic [19:0] seek_addr_out,
   output var logic [3:0]  seek_code_out,
   output var logic        rw_req_out
);
   initial
   begin
      seek_req_out  = 1'b0;
      seek_addr_out = 20'h0_0000;
      seek_code_out = 4'h0;
      rw_req_out    = 1'b0;
   end

   // Request held until an edge that finds the buffer free
   task automatic seek(input logic [19:0] a, input logic [3:0] c);
      logic r;
      @(posedge clk_in);
      seek_req_out  <= 1'b1;
      seek_addr_out <= a;
      seek_code_out <= c;
      do
      begin
         @(negedge clk_in);
         r = ready_in;
         @(posedge clk_in);
      end
      while (r !== 1'b1);
      seek_req_out  <= 1'b0;
      // Released lines must not keep showing the old value
      seek_addr_out <= ~a;
      seek_code_out <= ~c;
   endtask : seek

   task automatic rw();
      @(posedge clk_in);
      rw_req_out <= 1'b1;
      @(posedge clk_in);
      rw_req_out <= 1'b0;
   endtask : rw
endmodule : dar_cpu_model

`default_nettype wire

// *** test/test_disk_access_address_router.sv ***
// Self-checking bench of the disk access address router
`timescale 1ns/1ps
`default_nettype none

module test_disk_access_address_router;
   localparam int unsigned SEEK_N = 16;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ce = 1'b1;
   logic        second = 1'b0;
   logic        sel_mode = 1'b0;
   logic        sel0 = 1'b0;
   logic        sel1 = 1'b0;
   wire logic   s_req, rw_req, rdy, aerr, stb, rfile, rarm;
   wire logic [19:0] s_addr, raddr;
   wire logic [3:0]  s_code, start, busy;
   int          err_total = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          t_start, t0;
   logic        auto_arm, prev_arm, last_arm, last_file, hold4, sel_arm;
   logic [19:0] last_addr;

   always #50 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   dar_router #(.SEEK_CYCLES(SEEK_N)) i_dut (
      .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
      .SECOND_FILE_IN(second), .SEL_MODE_IN(sel_mode),
      .SEL_ARM0_IN(sel0), .SEL_ARM1_IN(sel1),
      .SEEK_REQ_IN(s_req), .SEEK_ADDR_IN(s_addr), .SEEK_CODE_IN(s_code),
      .SEEK_READY_OUT(rdy), .ADDR_ERR_OUT(aerr), .RW_REQ_IN(rw_req),
      .RW_STROBE_OUT(stb), .RW_FILE_OUT(rfile), .RW_ARM_OUT(rarm),
      .RW_ADDR_OUT(raddr), .SEEK_START_OUT(start), .ARM_BUSY_OUT(busy));

   dar_cpu_model cpu (
      .clk_in(clk), .ready_in(rdy), .seek_req_out(s_req),
      .seek_addr_out(s_addr), .seek_code_out(s_code), .rw_req_out(rw_req));

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic cmp_word(input logic [19:0] got, input logic [19:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_gap(input int got, input int least);
      n_checks++;
      if (got < least)
      begin
         err_total++;
         $display("unexpected at %0t: gap %0d below %0d", $time, got, least);
      end
   endtask : cmp_gap

   function automatic logic [19:0] rnd_addr(input logic up);
      logic [19:0] a;
      for (int i = 0; i < 4; i++)
         a[i*4 +: 4] = 4'($urandom % 10);
      a[19:16] = up ? 4'(5 + $urandom % 5) : 4'($urandom % 5);
      return a;
   endfunction : rnd_addr

   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      cmp_word(20'({rdy, stb, aerr, rfile, rarm, start, busy}), 20'h0_0000);
      cmp_word(raddr, 20'h0_0000);
      @(posedge clk);
      rst_n    <= 1'b1;
      sel_mode <= 1'b0;
      {auto_arm, prev_arm, last_arm, last_file, hold4, sel_arm} = 6'h00;
   endtask : do_reset

   task automatic do_seek(input logic [19:0] a, input logic [3:0] c);
      logic       f, arm;
      logic [3:0] idx;
      cpu.seek(a, c);
      f   = second && (a[19:16] >= 4'h5);
      arm = sel_mode ? sel_arm : auto_arm;
      idx = 4'h0;
      for (int i = 0; i < 200 && idx === 4'h0; i++)
      begin
         @(negedge clk);
         idx = start;
      end
      t_start = cyc;
      cmp_word(20'(idx), 20'(4'h1 << {f, arm}));
      cmp_word(20'(aerr), 20'(!second && a[19:16] >= 4'h5));
      if (!sel_mode)
      begin
         prev_arm = last_arm;
         auto_arm = ~auto_arm;
      end
      last_arm  = arm;
      last_file = f;
      last_addr = a;
      hold4     = (c == 4'h4);
   endtask : do_seek

   task automatic do_rw;
      logic arm;
      arm = sel_mode ? sel_arm : (hold4 ? last_arm : prev_arm);
      cpu.rw();
      for (int i = 0; i < 200 && stb !== 1'b1; i++)
         @(negedge clk);
      cmp_word(20'(stb), 20'h0_0001);
      cmp_word(20'({rfile, rarm}), 20'({last_file, arm}));
      cmp_word(raddr, last_addr);
   endtask : do_rw

   task automatic pulse_sel(input logic which);
      @(posedge clk);
      sel0 <= !which;
      sel1 <= which;
      @(posedge clk);
      sel0 <= 1'b0;
      sel1 <= 1'b0;
      sel_arm = which;
   endtask : pulse_sel

   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      tally_and_finish();
   end

   initial
   begin
      void'($urandom(63));
      do_reset();
      // Boundaries on one file: upper addresses flagged, not folded
      do_seek(20'h4_9999, 4'h0);
      do_rw();
      do_seek(20'h9_9999, 4'h0);
      do_rw();
      cmp_word(20'(busy[1]), 20'h0_0001);
      @(posedge clk) second <= 1'b1;
      // Cross-file seeks must wait for the first arm
      do_seek(20'h0_1234, 4'h0);
      do_rw();
      t0 = t_start;
      do_seek(20'h5_0000, 4'h0);
      cmp_gap(t_start - t0, SEEK_N);
      // Readdress the first file before rewriting it
      do_seek(20'h0_1234, 4'h0);
      do_seek(20'h0_1234, 4'h4);
      do_rw();
      for (int k = 0; k < 12; k++)
      begin
         do_seek(rnd_addr(1'($urandom % 2)), ($urandom % 3 == 0) ? 4'h4 : 4'h0);
         do_rw();
      end
      // Switch to select mode without a reset
      @(posedge clk) sel_mode <= 1'b1;
      pulse_sel(1'b1);
      for (int k = 0; k < 3; k++)
      begin
         do_seek(rnd_addr(1'b0), 4'h0);
         do_rw();
      end
      pulse_sel(1'b0);
      do_seek(rnd_addr(1'b1), 4'h0);
      do_rw();
      // Second reset mid-run restarts alternation at arm 0
      @(posedge clk);
      do_reset();
      do_seek(rnd_addr(1'b1), 4'h0);
      // Enable low freezes the arm timer, so the seek outlasts its span
      @(posedge clk) ce <= 1'b0;
      repeat (SEEK_N + 4) @(posedge clk);
      ce <= 1'b1;
      repeat (2) @(negedge clk);
      cmp_word(20'(busy), 20'h0_0004);
      do_seek(rnd_addr(1'b1), 4'h0);
      do_rw();
      tally_and_finish();
   end
endmodule : test_disk_access_address_router

`default_nettype wire
